// File: logic/accumulator_add_pkg.sv
package accumulator_add_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ACC_W = 40;
  localparam int LONG_W = 32;
  localparam int WORD_W = 16;
  localparam int OPC_W = 24;
  localparam int APB_AW = 8;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_ACC_A_LOW = 8'h04;
  localparam logic [7:0] OFS_ACC_A_EXT = 8'h08;
  localparam logic [7:0] OFS_ACC_B_LOW = 8'h0c;
  localparam logic [7:0] OFS_ACC_B_EXT = 8'h10;
  localparam logic [7:0] OFS_FIRST_PAIR = 8'h14;
  localparam logic [7:0] OFS_SECOND_PAIR = 8'h18;
  localparam logic [7:0] OFS_EXT_WORD = 8'h1c;
  localparam logic [7:0] OFS_INSTR = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MOVE_LOW = 8'h28;
  localparam logic [7:0] OFS_MOVE_EXT = 8'h2c;

  // ---------------------------------------------------------------
  // Reset values and status fields
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [31:0] PAIR_RESET = 32'h0000_0000;
  localparam logic [23:0] INSTR_RESET = 24'h00_0000;
  localparam int STAT_ILLEGAL_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_COUNT_LSB = 16;

  // ---------------------------------------------------------------
  // Opcode fields and patterns
  // ---------------------------------------------------------------
  localparam int DEST_BIT = 3;
  localparam int CARRY_SRC_BIT = 4;
  localparam logic [2:0] LOW3_CARRY_SUM = 3'h1;
  localparam logic [2:0] LOW3_SUM = 3'h0;
  localparam logic [2:0] LOW3_SHIFT_SUM = 3'h2;
  localparam logic [2:0] HI3_CARRY_SUM = 3'h1;
  localparam logic [3:0] HI4_DOUBLE = 4'h1;
  localparam logic [3:0] HI4_HALVE = 4'h0;
  localparam logic [3:0] HI4_SHORT_IMM = 4'h8;
  localparam logic [3:0] HI4_LONG_IMM = 4'hc;
  localparam logic [9:0] SHORT_IMM_PREFIX = 10'h005;
  localparam logic [15:0] LONG_IMM_PREFIX = 16'h0140;

  // Codes of the three-bit source select field of the register sum.
  localparam logic [2:0] JSEL_OTHER_ACC = 3'h1;
  localparam logic [2:0] JSEL_FIRST_LONG = 3'h2;
  localparam logic [2:0] JSEL_SECOND_LONG = 3'h3;
  localparam logic [2:0] JSEL_FIRST_LOW = 3'h4;
  localparam logic [2:0] JSEL_SECOND_LOW = 3'h5;
  localparam logic [2:0] JSEL_FIRST_HIGH = 3'h6;
  localparam logic [2:0] JSEL_SECOND_HIGH = 3'h7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    op_none = 3'b000,
    op_carry_sum = 3'b001,
    op_sum = 3'b010,
    op_double_sum = 3'b011,
    op_halve_sum = 3'b100
  } op_kind_t;

  typedef enum logic [3:0] {
    src_other_acc = 4'b0000,
    src_first_long = 4'b0001,
    src_second_long = 4'b0010,
    src_first_low = 4'b0011,
    src_second_low = 4'b0100,
    src_first_high = 4'b0101,
    src_second_high = 4'b0110,
    src_short_imm = 4'b0111,
    src_long_imm = 4'b1000
  } src_sel_t;

  typedef struct packed {
    op_kind_t kind;
    src_sel_t src;
    logic dest_b;
    logic has_move;
  } dec_t;

  typedef struct packed {
    logic s;
    logic l;
    logic e;
    logic u;
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_t;

endpackage

// File: logic/accumulator_add_unit.sv
`timescale 1ns/100ps
module accumulator_add_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [accumulator_add_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state
  output accumulator_add_pkg::flags_t condition_flags,
  output logic busy
);
  import accumulator_add_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [ACC_W-1:0] long_to_acc(input logic [LONG_W-1:0] v);
    long_to_acc = {{(ACC_W-LONG_W){v[LONG_W-1]}}, v};
  endfunction

  // A 16-bit word sits in the upper half of the long part.
  function automatic logic [ACC_W-1:0] word_to_acc(input logic [WORD_W-1:0] v);
    word_to_acc = {{(ACC_W-LONG_W){v[WORD_W-1]}}, v, {WORD_W{1'b0}}};
  endfunction

  // Byte-wide registers read back in the low byte of a zero-filled word.
  function automatic logic [31:0] byte_to_word(input logic [7:0] b);
    byte_to_word = {24'h00_0000, b};
  endfunction

  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    case (a)
      OFS_FLAGS, OFS_ACC_A_LOW, OFS_ACC_A_EXT, OFS_ACC_B_LOW, OFS_ACC_B_EXT,
      OFS_FIRST_PAIR, OFS_SECOND_PAIR, OFS_EXT_WORD, OFS_INSTR, OFS_STATUS,
      OFS_MOVE_LOW, OFS_MOVE_EXT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [ACC_W-1:0] acc_a_ff;
  logic [ACC_W-1:0] acc_b_ff;
  logic [LONG_W-1:0] first_pair_ff;
  logic [LONG_W-1:0] second_pair_ff;
  logic [WORD_W-1:0] ext_word_ff;
  logic [OPC_W-1:0] instr_ff;
  flags_t flags_ff;
  logic exec_ff;
  logic illegal_ff;
  logic [15:0] op_count_ff;
  logic [ACC_W-1:0] move_snap_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Each access takes one wait state so that every bus output is a flop.
  wire logic access = psel & penable;
  wire logic first_access = access & ~pready_ff;
  wire logic commit = access & pready_ff;
  wire logic hit = is_mapped(paddr);
  wire logic wr = commit & pwrite & hit;
  wire logic wr_flags = wr & (paddr == OFS_FLAGS);
  wire logic wr_a_low = wr & (paddr == OFS_ACC_A_LOW);
  wire logic wr_a_ext = wr & (paddr == OFS_ACC_A_EXT);
  wire logic wr_b_low = wr & (paddr == OFS_ACC_B_LOW);
  wire logic wr_b_ext = wr & (paddr == OFS_ACC_B_EXT);
  wire logic wr_first = wr & (paddr == OFS_FIRST_PAIR);
  wire logic wr_second = wr & (paddr == OFS_SECOND_PAIR);
  wire logic wr_ext_word = wr & (paddr == OFS_EXT_WORD);
  wire logic wr_instr = wr & (paddr == OFS_INSTR);

  // ---------------------------------------------------------------
  // Operation decode and operand selection
  // ---------------------------------------------------------------
  dec_t dec;

  opcode_decoder u_decoder (
    .opcode(instr_ff),
    .dec(dec)
  );

  wire logic [ACC_W-1:0] dest_value = dec.dest_b ? acc_b_ff : acc_a_ff;
  wire logic [ACC_W-1:0] other_value = dec.dest_b ? acc_a_ff : acc_b_ff;
  wire logic [WORD_W-1:0] first_pair_low_word = first_pair_ff[WORD_W-1:0];
  wire logic [WORD_W-1:0] first_pair_high_word = first_pair_ff[LONG_W-1:WORD_W];
  wire logic [WORD_W-1:0] second_pair_low_word = second_pair_ff[WORD_W-1:0];
  wire logic [WORD_W-1:0] second_pair_high_word = second_pair_ff[LONG_W-1:WORD_W];
  // The short immediate is unsigned; the upper ten bits are zero-filled.
  wire logic [WORD_W-1:0] short_imm = {10'h000, instr_ff[13:8]};

  // ---------------------------------------------------------------
  // Extension bytes
  // ---------------------------------------------------------------
  wire logic [ACC_W-LONG_W-1:0] acc_first_extension_byte = acc_a_ff[ACC_W-1:LONG_W];
  wire logic [ACC_W-LONG_W-1:0] acc_second_extension_byte = acc_b_ff[ACC_W-1:LONG_W];
  wire logic [ACC_W-LONG_W-1:0] move_extension_byte = move_snap_ff[ACC_W-1:LONG_W];

  logic [ACC_W-1:0] src_value;

  always_comb begin
    case (dec.src)
      src_other_acc: src_value = other_value;
      src_first_long: src_value = long_to_acc(first_pair_ff);
      src_second_long: src_value = long_to_acc(second_pair_ff);
      src_first_low: src_value = word_to_acc(first_pair_low_word);
      src_second_low: src_value = word_to_acc(second_pair_low_word);
      src_first_high: src_value = word_to_acc(first_pair_high_word);
      src_second_high: src_value = word_to_acc(second_pair_high_word);
      src_short_imm: src_value = word_to_acc(short_imm);
      src_long_imm: src_value = word_to_acc(ext_word_ff);
      default: src_value = {ACC_W{1'b0}};
    endcase
  end

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  // Carry is bit 40 of the full sum. With a word, long or immediate source it is only
  // meaningful while the destination extension byte copies bit 31; nothing enforces that.
  // Accumulator sources always give a valid carry.
  logic [ACC_W-1:0] sum_result;
  flags_t sum_flags;

  sum_flag_unit #(
    .ACC_BITS(ACC_W)
  ) u_sum (
    .kind(dec.kind),
    .dest_value(dest_value),
    .src_value(src_value),
    .old_flags(flags_ff),
    .result(sum_result),
    .new_flags(sum_flags)
  );

  wire logic exec_ok = exec_ff & (dec.kind != op_none);
  wire logic exec_a = exec_ok & ~dec.dest_b;
  wire logic exec_b = exec_ok & dec.dest_b;

  // ---------------------------------------------------------------
  // Next register values
  // ---------------------------------------------------------------
  // An executing operation outranks a bus write to the same register.
  wire logic [ACC_W-1:0] bus_acc_a = {wr_a_ext ? pwdata[7:0] : acc_a_ff[ACC_W-1:LONG_W],
                                      wr_a_low ? pwdata : acc_a_ff[LONG_W-1:0]};
  wire logic [ACC_W-1:0] bus_acc_b = {wr_b_ext ? pwdata[7:0] : acc_b_ff[ACC_W-1:LONG_W],
                                      wr_b_low ? pwdata : acc_b_ff[LONG_W-1:0]};
  wire logic [ACC_W-1:0] nxt_acc_a = exec_a ? sum_result : bus_acc_a;
  wire logic [ACC_W-1:0] nxt_acc_b = exec_b ? sum_result : bus_acc_b;
  wire flags_t nxt_flags = exec_ok ? sum_flags :
                           wr_flags ? flags_t'(pwdata[7:0]) : flags_ff;
  // The move path captures the destination before the sum lands.
  wire logic [ACC_W-1:0] nxt_move_snap = (exec_ok & dec.has_move) ? dest_value
                                                                 : move_snap_ff;
  // An opcode that decodes to nothing changes no state except the illegal bit.
  wire logic nxt_illegal = exec_ff ? (dec.kind == op_none) : illegal_ff;
  // The executed-operation count wraps silently at 16 bits.
  wire logic [15:0] nxt_op_count = exec_ok ? op_count_ff + 16'h0001 : op_count_ff;

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_ILLEGAL_BIT] = illegal_ff;
    status_word[STAT_BUSY_BIT] = exec_ff;
    status_word[STAT_COUNT_LSB +: 16] = op_count_ff;
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] rd_data;

  always_comb begin
    case (paddr)
      OFS_FLAGS: rd_data = byte_to_word(flags_ff);
      OFS_ACC_A_LOW: rd_data = acc_a_ff[LONG_W-1:0];
      OFS_ACC_A_EXT: rd_data = byte_to_word(acc_first_extension_byte);
      OFS_ACC_B_LOW: rd_data = acc_b_ff[LONG_W-1:0];
      OFS_ACC_B_EXT: rd_data = byte_to_word(acc_second_extension_byte);
      OFS_FIRST_PAIR: rd_data = first_pair_ff;
      OFS_SECOND_PAIR: rd_data = second_pair_ff;
      OFS_EXT_WORD: rd_data = {16'h0000, ext_word_ff};
      OFS_INSTR: rd_data = {8'h00, instr_ff};
      OFS_STATUS: rd_data = status_word;
      OFS_MOVE_LOW: rd_data = move_snap_ff[LONG_W-1:0];
      OFS_MOVE_EXT: rd_data = byte_to_word(move_extension_byte);
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus handshake flops
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= first_access;
      pslverr_ff <= first_access & ~hit;
      prdata_ff <= (first_access & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Datapath registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a_ff <= ACC_RESET;
      acc_b_ff <= ACC_RESET;
      flags_ff <= flags_t'(FLAGS_RESET);
      move_snap_ff <= ACC_RESET;
    end else begin
      acc_a_ff <= nxt_acc_a;
      acc_b_ff <= nxt_acc_b;
      flags_ff <= nxt_flags;
      move_snap_ff <= nxt_move_snap;
    end
  end

  // ---------------------------------------------------------------
  // Source and instruction registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pair_ff <= PAIR_RESET;
      second_pair_ff <= PAIR_RESET;
      ext_word_ff <= 16'h0000;
      instr_ff <= INSTR_RESET;
    end else begin
      if (wr_first) begin
        first_pair_ff <= pwdata;
      end
      if (wr_second) begin
        second_pair_ff <= pwdata;
      end
      if (wr_ext_word) begin
        ext_word_ff <= pwdata[WORD_W-1:0];
      end
      if (wr_instr) begin
        instr_ff <= pwdata[OPC_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Execution control
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_ff <= 1'b0;
      illegal_ff <= 1'b0;
      op_count_ff <= 16'h0000;
    end else begin
      exec_ff <= wr_instr;
      illegal_ff <= nxt_illegal;
      op_count_ff <= nxt_op_count;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign condition_flags = flags_ff;
  assign busy = exec_ff;

endmodule

// File: logic/opcode_decoder.sv
`timescale 1ns/100ps
module opcode_decoder (
  // Opcode word
  input wire logic [accumulator_add_pkg::OPC_W-1:0] opcode,
  // Decoded operation
  output accumulator_add_pkg::dec_t dec
);
  import accumulator_add_pkg::*;

  // ---------------------------------------------------------------
  // Pattern match
  // ---------------------------------------------------------------
  function automatic src_sel_t field_to_src(input logic [2:0] code);
    case (code)
      JSEL_OTHER_ACC: field_to_src = src_other_acc;
      JSEL_FIRST_LONG: field_to_src = src_first_long;
      JSEL_SECOND_LONG: field_to_src = src_second_long;
      JSEL_FIRST_LOW: field_to_src = src_first_low;
      JSEL_SECOND_LOW: field_to_src = src_second_low;
      JSEL_FIRST_HIGH: field_to_src = src_first_high;
      default: field_to_src = src_second_high;
    endcase
  endfunction

  wire logic [7:0] lo = opcode[7:0];
  wire logic [2:0] source_select_field = lo[6:4];
  wire logic is_carry_sum = (lo[7:5] == HI3_CARRY_SUM) && (lo[2:0] == LOW3_CARRY_SUM);
  wire logic is_reg_sum = !lo[7] && (lo[2:0] == LOW3_SUM) && (source_select_field != 3'h0);
  wire logic is_double = (lo[7:4] == HI4_DOUBLE) && (lo[2:0] == LOW3_SHIFT_SUM);
  wire logic is_halve = (lo[7:4] == HI4_HALVE) && (lo[2:0] == LOW3_SHIFT_SUM);
  wire logic is_short = (opcode[23:14] == SHORT_IMM_PREFIX) && (lo[7:4] == HI4_SHORT_IMM)
                        && (lo[2:0] == LOW3_SUM);
  wire logic is_long = (opcode[23:8] == LONG_IMM_PREFIX) && (lo[7:4] == HI4_LONG_IMM)
                       && (lo[2:0] == LOW3_SUM);

  // ---------------------------------------------------------------
  // Decoded fields
  // ---------------------------------------------------------------
  wire op_kind_t kind = is_carry_sum ? op_carry_sum :
                        (is_reg_sum || is_short || is_long) ? op_sum :
                        is_double ? op_double_sum :
                        is_halve ? op_halve_sum : op_none;

  // Carry sum picks one long pair; shift sums use the other accumulator.
  wire src_sel_t src = is_carry_sum ? (lo[CARRY_SRC_BIT] ? src_second_long
                                                          : src_first_long) :
                       is_short ? src_short_imm :
                       is_long ? src_long_imm :
                       is_reg_sum ? field_to_src(source_select_field) :
                       src_other_acc;

  assign dec.kind = kind;
  assign dec.src = src;
  assign dec.dest_b = lo[DEST_BIT];
  assign dec.has_move = (kind != op_none) && !is_short && !is_long;

endmodule

// File: logic/sum_flag_unit.sv
`timescale 1ns/100ps
module sum_flag_unit #(
  parameter int ACC_BITS = 40
) (
  // Operands
  input accumulator_add_pkg::op_kind_t kind,
  input wire logic [ACC_BITS-1:0] dest_value,
  input wire logic [ACC_BITS-1:0] src_value,
  input accumulator_add_pkg::flags_t old_flags,
  // Result
  output logic [ACC_BITS-1:0] result,
  output accumulator_add_pkg::flags_t new_flags
);
  import accumulator_add_pkg::*;

  localparam int MSB = ACC_BITS - 1;

  // ---------------------------------------------------------------
  // Preliminary shift and addition
  // ---------------------------------------------------------------
  wire logic [MSB:0] shifted =
    (kind == op_double_sum) ? {dest_value[MSB-1:0], 1'b0} :
    (kind == op_halve_sum) ? {dest_value[MSB], dest_value[MSB:1]} :
    dest_value;
  wire logic carry_in = (kind == op_carry_sum) ? old_flags.c : 1'b0;
  wire logic [ACC_BITS:0] sum_wide = {1'b0, shifted} + {1'b0, src_value}
                                     + {{ACC_BITS{1'b0}}, carry_in};
  wire logic [MSB:0] sum = sum_wide[MSB:0];

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  wire logic add_ovf = (shifted[MSB] == src_value[MSB]) && (sum[MSB] != shifted[MSB]);
  wire logic shift_ovf = (kind == op_double_sum) && (dest_value[MSB] != dest_value[MSB-1]);
  wire logic ovf = add_ovf | shift_ovf;
  wire logic int_same = (&sum[MSB:31]) | ~(|sum[MSB:31]);

  assign result = sum;
  assign new_flags.c = sum_wide[ACC_BITS];
  assign new_flags.v = ovf;
  assign new_flags.z = (sum == {ACC_BITS{1'b0}});
  assign new_flags.n = sum[MSB];
  assign new_flags.u = ~(sum[31] ^ sum[30]);
  assign new_flags.e = ~int_same;
  assign new_flags.l = old_flags.l | ovf;
  assign new_flags.s = old_flags.s | (sum[30] ^ sum[29]);

endmodule

// File: sim/accumulator_add_monitor.sv
`timescale 1ns/100ps
module accumulator_add_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [accumulator_add_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core state
  input accumulator_add_pkg::flags_t condition_flags,
  input wire logic busy
);
  import accumulator_add_pkg::*;
  logic acc_end, instr_wr, flag_wr, l_now, s_now;
  assign acc_end = psel && penable && pready;
  assign instr_wr = acc_end && pwrite && !pslverr && paddr == OFS_INSTR;
  assign flag_wr = acc_end && pwrite && paddr == OFS_FLAGS;
  assign l_now = condition_flags.l;
  assign s_now = condition_flags.s;
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_qual_a: assert property (pslverr |-> acc_end)
    else $error("error outside access end");
  rdata_quiet_a: assert property (!(acc_end && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read end");
  exec_start_a: assert property (instr_wr |=> busy ##1 !busy)
    else $error("instruction write not executed");
  busy_cause_a: assert property ($rose(busy) |-> $past(instr_wr))
    else $error("busy without instruction write");
  flags_hold_a: assert property (!$past(busy) && !$past(flag_wr) |-> $stable(condition_flags))
    else $error("flags changed without cause");
  flags_sticky_a: assert property (busy && l_now && s_now |=> l_now && s_now)
    else $error("sticky flag cleared by operation");
endmodule
bind accumulator_add_unit accumulator_add_monitor u_accumulator_add_monitor (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .condition_flags, .busy);

// File: sim/fetch_side_model.sv
`timescale 1ns/100ps
module fetch_side_model (
  // Clock
  input wire logic pclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [accumulator_add_pkg::APB_AW-1:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready
);
  import accumulator_add_pkg::*;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Released address and write data lines are inverted so that stale values never look valid.
  task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 16);
    if (!pready) tb_top.tally_and_finish(1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
  task automatic run_instr(input logic [23:0] opc, input logic [15:0] ext);
    logic [31:0] q;
    xfer(1'b1, OFS_EXT_WORD, {16'h0, ext}, q);
    xfer(1'b1, OFS_INSTR, {8'h0, opc}, q);
  endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import accumulator_add_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, mx, my;
  flags_t condition_flags, mf;
  logic [39:0] ma, mb, mm;
  logic [32:0] expq[$];
  int n_errors = 0;
  int total_checks = 0;
  int seed = 6;
  always #25 pclk = ~pclk;
  accumulator_add_unit u_accumulator_add_unit (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .condition_flags, .busy);
  fetch_side_model u_fetch_side_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready);
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish(input int hung);
    n_errors += hung;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) check("read order", 33'h0, 33'h1);
      else check("read data", {pslverr, prdata}, expq.pop_front());
    end
  end
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_fetch_side_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [APB_AW-1:0] a, input logic [32:0] e);
    logic [31:0] q;
    expq.push_back(e);
    u_fetch_side_model.xfer(1'b0, a, 32'h0, q);
  endtask
  function automatic logic [39:0] sx(input logic [15:0] w);
    return {{8{w[15]}}, w, 16'h0};
  endfunction
  task automatic op(input int k, input logic d, input logic [2:0] j, input logic [15:0] im);
    logic [39:0] dst, src, sh, r;
    logic [40:0] s41;
    logic [23:0] opc;
    logic [31:0] lw;
    logic [15:0] w;
    logic v;
    dst = d ? mb : ma;
    sh = k == 2 ? {dst[38:0], 1'b0} : k == 3 ? {dst[39], dst[39:1]} : dst;
    case (k)
      0: opc = {16'h0, 3'b001, j[0], d, 3'b001};
      1: opc = {16'h0, 1'b0, j, d, 3'b000};
      2: opc = {16'h0, 4'b0001, d, 3'b010};
      3: opc = {16'h0, 4'b0000, d, 3'b010};
      4: opc = {10'h005, im[5:0], 4'b1000, d, 3'b000};
      default: opc = {16'h0140, 4'b1100, d, 3'b000};
    endcase
    lw = j[0] ? my : mx;
    w = j[1] ? lw[31:16] : lw[15:0];
    src = (k == 0 || (k == 1 && j[2:1] == 2'b01)) ? {{8{lw[31]}}, lw} : d ? ma : mb;
    if (k == 1 && j[2]) src = sx(w);
    if (k >= 4) src = sx(k == 4 ? {10'h0, im[5:0]} : im);
    s41 = {1'b0, sh} + {1'b0, src} + 41'(k == 0 && mf.c);
    r = s41[39:0];
    v = (sh[39] == src[39] && r[39] != sh[39]) || (k == 2 && dst[39] != dst[38]);
    if (k < 4) mm = dst;
    mf = '{s: mf.s | (r[30] ^ r[29]), l: mf.l | v, e: !(&r[39:31] || !(|r[39:31])),
      u: !(r[31] ^ r[30]), n: r[39], z: r == 40'h0, v: v, c: s41[40]};
    {mb, ma} = d ? {r, ma} : {mb, r};
    u_fetch_side_model.run_instr(opc, im);
    @(posedge pclk);
    check("busy", {32'h0, busy}, 33'h1);
    rd(OFS_ACC_A_LOW, {1'b0, ma[31:0]});
    rd(OFS_ACC_A_EXT, {25'h0, ma[39:32]});
    rd(OFS_ACC_B_LOW, {1'b0, mb[31:0]});
    rd(OFS_ACC_B_EXT, {25'h0, mb[39:32]});
    rd(OFS_FLAGS, {25'h0, mf});
    rd(OFS_MOVE_LOW, {1'b0, mm[31:0]});
    rd(OFS_MOVE_EXT, {25'h0, mm[39:32]});
    check("flag port", {25'h0, condition_flags}, {25'h0, mf});
  endtask
  initial begin
    logic [63:0] r64;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) rd(8'(i * 4), 33'h0);
    wr(8'h34, 32'h5a5a_5a5a);
    rd(8'h34, {1'b1, 32'h0});
    {ma, mb, mx, my, mf, mm} = '0;
    for (int i = 0; i < 72; i++) begin
      r64 = {$random(seed), $random(seed)};
      ma = i % 4 == 0 ? 40'h7f_ffff_ffff : r64[39:0];
      r64 = {$random(seed), $random(seed)};
      mb = i % 5 == 0 ? 40'h80_0000_0000 : r64[39:0];
      {mx, my} = {$random(seed), $random(seed)};
      r64 = {$random(seed), $random(seed)};
      mf = r64[7:0];
      wr(OFS_ACC_A_LOW, ma[31:0]);
      wr(OFS_ACC_A_EXT, {24'h0, ma[39:32]});
      wr(OFS_ACC_B_LOW, mb[31:0]);
      wr(OFS_ACC_B_EXT, {24'h0, mb[39:32]});
      wr(OFS_FIRST_PAIR, mx);
      wr(OFS_SECOND_PAIR, my);
      wr(OFS_FLAGS, {24'h0, mf});
      op(i % 6, r64[8], 3'(1 + r64[11:9] % 7), r64[31:16]);
    end
    u_fetch_side_model.run_instr(24'h00_0000, 16'h0000);
    rd(OFS_STATUS, {1'b0, 16'h0048, 16'h0001});
    rd(OFS_FLAGS, {25'h0, mf});
    @(posedge pclk);
    check("pending reads", 33'(expq.size()), 33'h0);
    tally_and_finish(0);
  end
endmodule
